// ### common/ctwr_consts.svh
// constants for the transfer, watchdog test and exchange execution slice
`ifndef CTWR_CONSTS_SVH
`define CTWR_CONSTS_SVH

// ****************************************************************
// opcode patterns and masks
// ****************************************************************
`define CTWR_OPC_COPY_ACC_Y   10'h00c
`define CTWR_OPC_WDF_TEST     10'h0a0
`define CTWR_OPC_SWAP         10'h2d0
`define CTWR_OPC_SWAP_DEC     10'h2f0
`define CTWR_MASK_FULL        10'h3ff
`define CTWR_MASK_IMM         10'h3f0

// ****************************************************************
// field positions and values
// ****************************************************************
`define CTWR_IMM_MSB          3
`define CTWR_IMM_LSB          0
`define CTWR_Y_WRAP_VAL       4'hf
`define CTWR_Y_STEP           4'h1

// ****************************************************************
// reset values
// ****************************************************************
`define CTWR_RST_NIBBLE       4'h0
`define CTWR_RST_FLAG         1'b0

`endif

// ### common/ctwr_pkg.sv
// types shared by the execution slice
`default_nettype none

package ctwr_pkg;

  // ****************************************************************
  // sequencing states, one-hot
  // ****************************************************************
  typedef enum logic [1:0] {
    CTWR_EXEC = 2'h1,
    CTWR_SKIP = 2'h2
  } ctwr_state_e;

  typedef logic [3:0] ctwr_nibble_t;
  typedef logic [9:0] ctwr_word_t;

endpackage : ctwr_pkg

`default_nettype wire

// ### verilog/ctwr_core.sv
// execution logic for copy, watchdog flag test and swap instructions
// Behaviour
// - opcode 0x00c copies accumulator into Y, no skip
// - watchdog test skips next when expiry flag set, then clears it
// - opcode 101101jjjj swaps accumulator with RAM nibble at pointer
// - swap then replaces X with X xor immediate j, any j 0..15
// - opcode 101111jjjj does same swap and xor, plus Y adjust
// - decrement variant: Y minus one mod 16, skip next if Y is 15
`include "ctwr_consts.svh"
`default_nettype none

module ctwr_core
  import ctwr_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              RST,
  input  wire logic              CE,
  input  wire logic              INSTR_VALID,
  input  wire logic [9:0]        INSTR,
  input  wire logic [3:0]        MEM_RDATA,
  input  wire logic              WDT_EXPIRE,
  output logic                   MEM_WE,
  output logic      [3:0]        MEM_WDATA,
  output logic      [3:0]        ACC,
  output logic      [3:0]        XPTR,
  output logic      [3:0]        YPTR,
  output logic                   WDF,
  output logic                   SKIP_PENDING
);

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  function automatic logic op_match(input ctwr_word_t ins,
                                    input ctwr_word_t pat,
                                    input ctwr_word_t msk);
    op_match = ((ins & msk) == pat);
  endfunction : op_match

  ctwr_state_e  state_q, state_d;
  ctwr_nibble_t acc_q, acc_d;
  ctwr_nibble_t x_q, x_d;
  ctwr_nibble_t y_q, y_d;
  ctwr_nibble_t y_dec;
  ctwr_nibble_t imm;
  logic         wdf_q, wdf_d;
  logic         exec;
  logic         is_copy, is_test, is_swap, is_swap_dec, any_swap;
  logic         take_skip;

  // instruction is live only when not suppressed
  assign exec        = CE && INSTR_VALID && (state_q == CTWR_EXEC);
  assign is_copy     = op_match(INSTR, `CTWR_OPC_COPY_ACC_Y, `CTWR_MASK_FULL);
  assign is_test     = op_match(INSTR, `CTWR_OPC_WDF_TEST, `CTWR_MASK_FULL);
  assign is_swap     = op_match(INSTR, `CTWR_OPC_SWAP, `CTWR_MASK_IMM);
  assign is_swap_dec = op_match(INSTR, `CTWR_OPC_SWAP_DEC, `CTWR_MASK_IMM);
  assign any_swap    = is_swap || is_swap_dec;
  assign imm         = INSTR[`CTWR_IMM_MSB:`CTWR_IMM_LSB];
  assign y_dec       = y_q - `CTWR_Y_STEP;

  // ****************************************************************
  // register next values
  // ****************************************************************
  always_comb begin
    acc_d     = acc_q;
    x_d       = x_q;
    y_d       = y_q;
    take_skip = 1'b0;
    if (exec) begin
      if (is_copy) begin
        y_d = acc_q;
      end
      if (any_swap) begin
        acc_d = MEM_RDATA;
        x_d   = x_q ^ imm;
      end
      if (is_swap_dec) begin
        y_d       = y_dec;
        take_skip = (y_dec == `CTWR_Y_WRAP_VAL);
      end
      if (is_test && wdf_q) begin
        take_skip = 1'b1;
      end
    end
  end

  // ****************************************************************
  // watchdog expiry flag, set wins over clear
  // ****************************************************************
  always_comb begin
    wdf_d = wdf_q;
    if (CE) begin
      if (exec && is_test) begin
        wdf_d = `CTWR_RST_FLAG;
      end
      if (WDT_EXPIRE) begin
        wdf_d = 1'b1;
      end
    end
  end

  // ****************************************************************
  // skip sequencing
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      CTWR_EXEC: begin
        if (take_skip) begin
          state_d = CTWR_SKIP;
        end
      end
      CTWR_SKIP: begin
        if (CE && INSTR_VALID) begin
          state_d = CTWR_EXEC;
        end
      end
      default: begin
        state_d = CTWR_EXEC;
      end
    endcase
  end

  // state registers, frozen while CE low
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_q <= CTWR_EXEC;
      acc_q   <= `CTWR_RST_NIBBLE;
      x_q     <= `CTWR_RST_NIBBLE;
      y_q     <= `CTWR_RST_NIBBLE;
      wdf_q   <= `CTWR_RST_FLAG;
    end else if (CE) begin
      state_q <= state_d;
      acc_q   <= acc_d;
      x_q     <= x_d;
      y_q     <= y_d;
      wdf_q   <= wdf_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // no write when suppressed
  assign MEM_WE       = exec && any_swap;
  assign MEM_WDATA    = acc_q;   // old accumulator goes to ram
  assign ACC          = acc_q;
  assign XPTR         = x_q;
  assign YPTR         = y_q;
  assign WDF          = wdf_q;
  assign SKIP_PENDING = (state_q == CTWR_SKIP);

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  AST_COPY_Y: assert property (
    exec && is_copy |=> YPTR == $past(acc_q) && XPTR == $past(x_q)
      && !SKIP_PENDING)
    else $error("copy did not load Y from accumulator");

  AST_TEST_SKIP: assert property (
    exec && is_test && wdf_q |=> SKIP_PENDING ##0 (!WDF || $past(WDT_EXPIRE)))
    else $error("flag test did not skip and clear");

  AST_TEST_NOSKIP: assert property (
    exec && is_test && !wdf_q |=> !SKIP_PENDING)
    else $error("flag test skipped with flag clear");

  AST_SWAP_DATA: assert property (
    exec && is_swap |-> MEM_WE && MEM_WDATA == acc_q
      ##1 ACC == $past(MEM_RDATA) && !SKIP_PENDING)
    else $error("swap did not exchange accumulator and ram");

  AST_SWAP_XOR: assert property (
    exec && any_swap |=> XPTR == ($past(x_q) ^ $past(imm)))
    else $error("X not xored with immediate");

  AST_SWAP_DEC_SWAP: assert property (
    exec && is_swap_dec |-> MEM_WE ##1 ACC == $past(MEM_RDATA))
    else $error("decrement swap did not exchange");

  AST_DEC_Y: assert property (
    exec && is_swap_dec |=> YPTR == 4'(($past(y_q) - 4'h1))
      && SKIP_PENDING == ($past(y_q) == 4'h0))
    else $error("Y decrement or wrap skip wrong");

  AST_SUPPRESS: assert property (
    SKIP_PENDING && CE && INSTR_VALID |-> !MEM_WE
      ##1 $stable(ACC) && $stable(XPTR) && $stable(YPTR) && !SKIP_PENDING)
    else $error("suppressed instruction changed state");

  AST_SET_WINS: assert property (
    CE && WDT_EXPIRE |=> WDF)
    else $error("expiry did not set the flag");

  AST_TEST_CLEAR: assert property (
    exec && is_test && !WDT_EXPIRE |=> !WDF)
    else $error("flag test did not clear the flag");

  AST_IDLE_SLOT: assert property (
    SKIP_PENDING && !(CE && INSTR_VALID) |=> SKIP_PENDING)
    else $error("idle slot consumed a pending skip");

  AST_SWAP_KEEPS_Y: assert property (
    exec && is_swap |=> $stable(YPTR))
    else $error("plain swap changed Y");

  AST_FREEZE: assert property (
    !CE |-> !MEM_WE ##1 $stable(ACC) && $stable(XPTR) && $stable(YPTR)
      && $stable(WDF) && $stable(SKIP_PENDING))
    else $error("state moved while enable was low");

endmodule : ctwr_core

`default_nettype wire

// ### dv/tb.sv
// self-checking bench for the copy, flag test and swap execution slice
`include "ctwr_consts.svh"
`default_nettype none

module tb;
  import ctwr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // stimulus, observed outputs and counters
  // ****************************************************************
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         ce = 1'b1;
  logic         valid = 1'b0;
  logic         expire = 1'b0;
  ctwr_word_t   instr = '0;
  ctwr_nibble_t rdata = '0;
  logic         mem_we, wdf, skip;
  ctwr_nibble_t wdata, acc, xptr, yptr;
  ctwr_nibble_t acc_e = 4'h0;
  ctwr_nibble_t x_e = 4'h0;
  int           miscompares = 0;
  int           tests_run = 0;
  int           cycles = 0;

  ctwr_core ctwr_core_i (.CLK(clk), .RST(rst), .CE(ce),
    .INSTR_VALID(valid), .INSTR(instr), .MEM_RDATA(rdata),
    .WDT_EXPIRE(expire), .MEM_WE(mem_we), .MEM_WDATA(wdata), .ACC(acc),
    .XPTR(xptr), .YPTR(yptr), .WDF(wdf), .SKIP_PENDING(skip));

  // clock and hang guard
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      miscompares = miscompares + 1;
      report_and_stop();
    end
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input string nm, input logic [3:0] seen,
                       input logic [3:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // one slot driven at the falling edge, outputs settled on return
  task automatic step(input logic v, input ctwr_word_t i,
                      input ctwr_nibble_t rd, input logic e);
    @(negedge clk);
    valid = v;
    instr = i;
    rdata = rd;
    expire = e;
    #1;
  endtask : step

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  // ****************************************************************
  // scenarios
  // ****************************************************************
  // every immediate, back to back, old accumulator goes to memory
  task automatic t_swap();
    for (int j = 0; j < 16; j++) begin
      step(1'b1, `CTWR_OPC_SWAP | 10'(j), 4'(j) ^ 4'h5, 1'b0);
      check("mem_we", {3'h0, mem_we}, 4'h1);
      check("wdata", wdata, acc_e);
      check("acc", acc, acc_e);
      check("xptr", xptr, x_e);
      acc_e = 4'(j) ^ 4'h5;
      x_e = x_e ^ 4'(j);
    end
  endtask : t_swap

  // accumulator into y, then prepare y = 0
  task automatic t_copy();
    step(1'b1, `CTWR_OPC_COPY_ACC_Y, 4'h0, 1'b0);
    check("mem_we", {3'h0, mem_we}, 4'h0);
    step(1'b1, `CTWR_OPC_SWAP, 4'h0, 1'b0);
    check("yptr", yptr, acc_e);
    check("skip", {3'h0, skip}, 4'h0);
    acc_e = 4'h0;
    step(1'b1, `CTWR_OPC_COPY_ACC_Y, 4'h0, 1'b0);
    step(1'b0, '0, 4'h0, 1'b0);
    check("yptr", yptr, 4'h0);
  endtask : t_copy

  // decrement wraps to 15 and skips a swap, then no skip at 14
  task automatic t_dec();
    step(1'b1, `CTWR_OPC_SWAP_DEC | 10'h3, 4'h9, 1'b0);
    check("mem_we", {3'h0, mem_we}, 4'h1);
    step(1'b1, `CTWR_OPC_SWAP | 10'h1, 4'h7, 1'b0);
    check("mem_we", {3'h0, mem_we}, 4'h0);
    check("yptr", yptr, 4'hf);
    check("acc", acc, 4'h9);
    check("xptr", xptr, x_e ^ 4'h3);
    check("skip", {3'h0, skip}, 4'h1);
    step(1'b1, `CTWR_OPC_SWAP_DEC, 4'h2, 1'b0);
    check("acc", acc, 4'h9);
    check("xptr", xptr, x_e ^ 4'h3);
    step(1'b0, '0, 4'h0, 1'b0);
    check("yptr", yptr, 4'he);
    check("skip", {3'h0, skip}, 4'h0);
    check("acc", acc, 4'h2);
    acc_e = 4'h2;
    x_e = x_e ^ 4'h3;
  endtask : t_dec

  // flag set, tested with skip and cleared, tested again without skip
  task automatic t_wdf();
    step(1'b0, '0, 4'h0, 1'b1);
    step(1'b0, '0, 4'h0, 1'b0);
    check("wdf", {3'h0, wdf}, 4'h1);
    step(1'b1, `CTWR_OPC_WDF_TEST, 4'h0, 1'b0);
    step(1'b1, `CTWR_OPC_SWAP | 10'hf, 4'h4, 1'b0);
    check("wdf", {3'h0, wdf}, 4'h0);
    check("skip", {3'h0, skip}, 4'h1);
    check("mem_we", {3'h0, mem_we}, 4'h0);
    step(1'b1, `CTWR_OPC_WDF_TEST, 4'h0, 1'b0);
    check("xptr", xptr, x_e);
    step(1'b0, '0, 4'h0, 1'b0);
    check("skip", {3'h0, skip}, 4'h0);
  endtask : t_wdf

  // enable low freezes a swap and a flag set, then the slot runs
  task automatic t_ce();
    @(negedge clk);
    ce = 1'b0;
    valid = 1'b1;
    instr = `CTWR_OPC_SWAP | 10'h6;
    rdata = 4'hc;
    expire = 1'b1;
    #1;
    check("mem_we", {3'h0, mem_we}, 4'h0);
    @(negedge clk);
    ce = 1'b1;
    expire = 1'b0;
    #1;
    check("acc", acc, acc_e);
    check("xptr", xptr, x_e);
    check("wdf", {3'h0, wdf}, 4'h0);
    check("mem_we", {3'h0, mem_we}, 4'h1);
    step(1'b0, '0, 4'h0, 1'b0);
    check("acc", acc, 4'hc);
    check("xptr", xptr, x_e ^ 4'h6);
    acc_e = 4'hc;
    x_e = x_e ^ 4'h6;
  endtask : t_ce

  // expiry on the clearing edge keeps the flag, idle slots keep a skip
  task automatic t_race();
    step(1'b0, '0, 4'h0, 1'b1);
    step(1'b1, `CTWR_OPC_WDF_TEST, 4'h0, 1'b1);
    step(1'b0, '0, 4'h0, 1'b0);
    check("wdf", {3'h0, wdf}, 4'h1);
    check("skip", {3'h0, skip}, 4'h1);
    step(1'b1, `CTWR_OPC_COPY_ACC_Y, 4'h0, 1'b0);
    check("skip", {3'h0, skip}, 4'h1);
    step(1'b1, `CTWR_OPC_WDF_TEST, 4'h0, 1'b0);
    check("yptr", yptr, 4'he);
    check("skip", {3'h0, skip}, 4'h0);
    step(1'b0, '0, 4'h0, 1'b0);
    check("wdf", {3'h0, wdf}, 4'h0);
    check("skip", {3'h0, skip}, 4'h1);
    step(1'b1, `CTWR_OPC_SWAP | 10'h9, 4'h3, 1'b0);
    step(1'b0, '0, 4'h0, 1'b0);
    check("acc", acc, acc_e);
    check("xptr", xptr, x_e);
    check("skip", {3'h0, skip}, 4'h0);
  endtask : t_race

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t_swap();
    t_copy();
    t_dec();
    t_wdf();
    t_ce();
    t_race();
    report_and_stop();
  end

endmodule : tb

`default_nettype wire
